// ==== design/dual_slope_pwm_timer16.v ====
// dual-slope (phase correct, phase and frequency correct) pwm timer core
//
// Notes on behaviour
// [R1] modes 1,2,3,10,11: phase correct, count 0 up to top and back down.
// [R2] non-inverting clears on up-count match, sets on down-count match; inverting opposite.
// [R3] top is 0x00ff/0x01ff/0x03ff in modes 1-3, capture in 10, compare a in 11.
// [R4] counter holds top for one timer tick, then counts down.
// [R5] software keeps programmed top between 0x0003 and 0xffff.
// [R6] phase correct: overflow flag set whenever counter arrives at zero.
// [R7] phase correct: buffers load at top; compare a or capture flag set then.
// [R8] compare flag of a channel set when count equals its compare value.
// [R9] fixed top modes mask compare writes above the resolution to zero.
// [R10] changing top: falling slope uses old top, rising slope new top.
// [R11] software prefers phase and frequency correct modes when changing top live.
// [R12] action 2 non-inverted, 3 inverted; pin driven only when direction bit set.
// [R13] compare zero gives constant low, equal to top constant high; inverted opposite.
// [R14] mode 11 with action a of 1 toggles output a on each match.
// [R15] modes 8 and 9: phase and frequency correct, top from capture or compare a.
// [R16] freq correct: buffers load at zero, overflow flag set same tick.
// [R17] freq correct: compare a or capture flag set when counter reaches top.
// [R18] mode 9 with action a of 1 toggles output a on each match.
// [R19] timer ticks come from prescaled enable; period is twice factor times top.
// [R20] software keeps top at or above compare values; else no match occurs.
// [R21] capture register unbuffered; compare a writes go through its buffer.
// [R22] action 1 toggles only output a in modes 9 or 11; else pin released.
// [R23] dual-slope writes land in buffer; matching always uses the active copy.
`timescale 1ns/1ps
`include "pwm_timer_regs.vh"

module dual_slope_pwm_timer16 (
    input  wire        mclk,
    input  wire        rst_n,
    input  wire        timer_tick,
    input  wire [3:0]  waveform_select_field,
    input  wire [1:0]  output_action_a_field,
    input  wire [1:0]  output_action_b_field,
    input  wire        pin_direction_a_bit,
    input  wire        pin_direction_b_bit,
    input  wire [15:0] write_data,
    input  wire        compare_a_write,
    input  wire        compare_b_write,
    input  wire        capture_write,
    input  wire        overflow_clear,
    input  wire        compare_a_clear,
    input  wire        compare_b_clear,
    input  wire        capture_clear,
    output reg  [15:0] count_value,
    output reg  [15:0] compare_a_reg,
    output reg  [15:0] compare_b_reg,
    output reg  [15:0] capture_top_reg,
    output reg         count_up_reg,
    output reg         overflow_flag,
    output reg         compare_a_flag,
    output reg         compare_b_flag,
    output reg         capture_flag,
    output reg         compare_output_a,
    output reg         compare_output_b,
    output reg         pin_a_oe_n,
    output reg         pin_b_oe_n
);

    // mode decode helpers; only fixed_mask is used in more than one place
    function is_pc;
        input [3:0] m;
        begin
            is_pc = (m == `WAVE_PC8) || (m == `WAVE_PC9) || (m == `WAVE_PC10) ||
                    (m == `WAVE_PC_CAP) || (m == `WAVE_PC_CMPA); // [R1]
        end
    endfunction

    function is_pfc;
        input [3:0] m;
        begin
            is_pfc = (m == `WAVE_PFC_CAP) || (m == `WAVE_PFC_CMPA); // [R15]
        end
    endfunction

    function [15:0] fixed_mask;
        input [3:0] m;
        begin
            case (m)
                `WAVE_PC8:  fixed_mask = `TOP_8BIT;
                `WAVE_PC9:  fixed_mask = `TOP_9BIT;
                `WAVE_PC10: fixed_mask = `TOP_10BIT;
                default:    fixed_mask = `MAX_VALUE;
            endcase
        end
    endfunction

    // one compare channel's next level on a match
    function match_level;
        input [1:0]  act;
        input        up;
        input        cur;
        input [15:0] cmp;
        input [15:0] top;
        reg          base;
        begin
            base = ~up; // [R2]
            if (cmp == `BOTTOM_VALUE)
                base = 1'b0; // [R13]
            else if (cmp == top)
                base = 1'b1; // [R13]
            case (act)
                `ACT_NONINV: match_level = base; // [R12]
                `ACT_INV:    match_level = ~base; // [R12]
                `ACT_TOGGLE: match_level = ~cur;
                default:     match_level = cur;
            endcase
        end
    endfunction

    wire [3:0] mode = waveform_select_field;
    wire       pc_mode = is_pc(mode);
    wire       pfc_mode = is_pfc(mode);
    wire       dual = pc_mode | pfc_mode;
    wire       top_from_cap = (mode == `WAVE_PC_CAP) || (mode == `WAVE_PFC_CAP);
    wire       top_from_a = (mode == `WAVE_PC_CMPA) || (mode == `WAVE_PFC_CMPA);
    wire       toggle_ok = (mode == `WAVE_PC_CMPA) || (mode == `WAVE_PFC_CMPA); // [R22]

    reg  [15:0] buffer_a_reg;
    reg  [15:0] buffer_b_reg;
    reg  [15:0] top_value;
    reg  [15:0] count_next;
    reg         up_next;
    wire [15:0] masked_data;

    // top selection; capture acts at once, compare a only after reload
    always @* begin
        if (top_from_cap)
            top_value = capture_top_reg; // [R3] [R21]
        else if (top_from_a)
            top_value = compare_a_reg; // [R3]
        else
            top_value = fixed_mask(mode); // [R3]
    end

    // fixed resolutions drop the upper bits on write
    assign masked_data = write_data & fixed_mask(mode); // [R9]

    // events seen on this tick; all compares use the active copies
    wire at_top = timer_tick && dual && (count_value == top_value);
    wire at_bottom = timer_tick && dual && (count_value == `BOTTOM_VALUE);
    wire match_a = timer_tick && dual && (count_value == compare_a_reg); // [R8] [R23]
    wire match_b = timer_tick && dual && (count_value == compare_b_reg); // [R8] [R23]
    wire reload = pc_mode ? at_top : at_bottom; // [R7] [R16] [R10]

    // count sequence: up to top, top for one tick, then down to zero
    always @* begin
        count_next = count_value;
        up_next = count_up_reg;
        if (timer_tick && dual) begin // [R19]
            if (count_up_reg) begin
                if (count_value == top_value) begin
                    up_next = 1'b0; // [R4]
                    count_next = count_value - 16'h0001;
                end else begin
                    // past top after a lowered capture: wraps through max
                    count_next = count_value + 16'h0001; // [R20]
                end
            end else begin
                if (count_value == `BOTTOM_VALUE) begin
                    up_next = 1'b1; // [R1]
                    count_next = count_value + 16'h0001;
                end else begin
                    count_next = count_value - 16'h0001;
                end
            end
        end
    end

    // counter and direction
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            count_value <= `COUNT_RESET;
            count_up_reg <= 1'b1;
        end else begin
            count_value <= count_next;
            count_up_reg <= up_next;
        end
    end

    // compare buffers; outside dual-slope modes writes take effect at once
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            buffer_a_reg <= `COMPARE_RESET;
            buffer_b_reg <= `COMPARE_RESET;
            compare_a_reg <= `COMPARE_RESET;
            compare_b_reg <= `COMPARE_RESET;
            capture_top_reg <= `COMPARE_RESET;
        end else begin
            if (compare_a_write)
                buffer_a_reg <= masked_data; // [R21] [R23]
            if (compare_b_write)
                buffer_b_reg <= masked_data; // [R23]
            if (capture_write)
                capture_top_reg <= write_data; // [R21]
            if (!dual) begin
                if (compare_a_write)
                    compare_a_reg <= masked_data;
                if (compare_b_write)
                    compare_b_reg <= masked_data;
            end else if (reload) begin
                // a write in the reload tick itself is taken directly
                compare_a_reg <= compare_a_write ? masked_data : buffer_a_reg; // [R7] [R16]
                compare_b_reg <= compare_b_write ? masked_data : buffer_b_reg; // [R7] [R16]
            end
        end
    end

    // sticky flags: a set in the clear cycle wins
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            overflow_flag <= 1'b0;
            compare_a_flag <= 1'b0;
            compare_b_flag <= 1'b0;
            capture_flag <= 1'b0;
        end else begin
            if (at_bottom)
                overflow_flag <= 1'b1; // [R6] [R16]
            else if (overflow_clear)
                overflow_flag <= 1'b0;
            if (match_a || (at_top && top_from_a))
                compare_a_flag <= 1'b1; // [R8] [R7] [R17]
            else if (compare_a_clear)
                compare_a_flag <= 1'b0;
            if (match_b)
                compare_b_flag <= 1'b1; // [R8]
            else if (compare_b_clear)
                compare_b_flag <= 1'b0;
            if (at_top && top_from_cap)
                capture_flag <= 1'b1; // [R7] [R17]
            else if (capture_clear)
                capture_flag <= 1'b0;
        end
    end

    // channel connection to the pin
    wire act_a_on = (output_action_a_field == `ACT_NONINV) ||
                    (output_action_a_field == `ACT_INV) ||
                    ((output_action_a_field == `ACT_TOGGLE) && toggle_ok); // [R22] [R14] [R18]
    wire act_b_on = (output_action_b_field == `ACT_NONINV) ||
                    (output_action_b_field == `ACT_INV); // [R22]

    // waveform levels, updated only on matches of an attached channel
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            compare_output_a <= 1'b0;
            compare_output_b <= 1'b0;
        end else begin
            if (match_a && act_a_on)
                compare_output_a <= match_level(output_action_a_field, count_up_reg,
                                                compare_output_a, compare_a_reg,
                                                top_value); // [R2] [R13] [R14] [R18]
            if (match_b && act_b_on)
                compare_output_b <= match_level(output_action_b_field, count_up_reg,
                                                compare_output_b, compare_b_reg,
                                                top_value); // [R2] [R13]
        end
    end

    // pin drivers: active low enable, only with direction set and channel attached
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_a_oe_n <= 1'b1;
            pin_b_oe_n <= 1'b1;
        end else begin
            pin_a_oe_n <= ~(pin_direction_a_bit && act_a_on && dual); // [R12]
            pin_b_oe_n <= ~(pin_direction_b_bit && act_b_on && dual); // [R12]
        end
    end

endmodule

// ==== inc/pwm_timer_regs.vh ====
// constants for the dual-slope 16-bit pwm timer
`ifndef PWM_TIMER_REGS_VH
`define PWM_TIMER_REGS_VH

// waveform select codes handled here
`define WAVE_PC8        4'h1
`define WAVE_PC9        4'h2
`define WAVE_PC10       4'h3
`define WAVE_PFC_CAP    4'h8
`define WAVE_PFC_CMPA   4'h9
`define WAVE_PC_CAP     4'ha
`define WAVE_PC_CMPA    4'hb

// fixed top values, count bottom and programmed top limits
`define TOP_8BIT        16'h00ff
`define TOP_9BIT        16'h01ff
`define TOP_10BIT       16'h03ff
`define BOTTOM_VALUE    16'h0000
`define MAX_VALUE       16'hffff
`define MIN_PROG_TOP    16'h0003

// output action field codes
`define ACT_OFF         2'h0
`define ACT_TOGGLE      2'h1
`define ACT_NONINV      2'h2
`define ACT_INV         2'h3

// reset values
`define COUNT_RESET     16'h0000
`define COMPARE_RESET   16'h0000

`endif

// ==== verification/pwm_timer_properties.sv ====
// port assertions for the dual-slope pwm timer
`timescale 1ns/1ps
module pwm_timer_props (
    input wire        mclk, rst_n, timer_tick, count_up_reg, pin_direction_a_bit,
    input wire [3:0]  waveform_select_field,
    input wire [1:0]  output_action_a_field, output_action_b_field,
    input wire [15:0] count_value, compare_a_reg, compare_b_reg, capture_top_reg,
    input wire        overflow_flag, compare_a_flag, capture_flag, compare_output_a, compare_output_b, pin_a_oe_n
);
    // a tick only moves the counter in the dual-slope codes
    wire [3:0] m    = waveform_select_field;
    wire       step = timer_tick && ((m >= 4'h1 && m <= 4'h3) || (m >= 4'h8 && m <= 4'hb));
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_top_turn_down: assert property (
        step && m == 4'h1 && count_value == 16'h00ff |=> count_value == 16'h00fe && !count_up_reg)
        else $error("no turn at top");
    a_down_step: assert property (
        step && !count_up_reg && count_value != 16'h0000 |=> count_value == $past(count_value) - 16'h0001)
        else $error("bad down step");
    a_bottom_overflow: assert property (
        step && count_value == 16'h0000 |=> overflow_flag) else $error("overflow flag missing");
    a_match_flag_a: assert property (
        step && count_value == compare_a_reg |=> compare_a_flag) else $error("compare a flag missing");
    a_capture_top_flag: assert property (
        step && (m == 4'h8 || m == 4'ha) && count_value == capture_top_reg |=> capture_flag)
        else $error("capture flag missing");
    a_noninv_up_clear: assert property (
        step && m == 4'h1 && output_action_b_field == 2'h2 && count_up_reg && count_value == compare_b_reg
        && count_value != 16'h00ff |=> !compare_output_b) else $error("b not cleared upward");
    a_inv_down_clear: assert property (
        step && m == 4'h1 && output_action_a_field == 2'h3 && !count_up_reg && count_value == compare_a_reg
        && compare_a_reg != 16'h0000 |=> !compare_output_a) else $error("a not cleared downward");
    a_toggle_a: assert property (
        step && (m == 4'h9 || m == 4'hb) && output_action_a_field == 2'h1 && count_value == compare_a_reg
        |=> compare_output_a != $past(compare_output_a)) else $error("a did not toggle");
    a_pin_a_release: assert property (
        !pin_direction_a_bit || output_action_a_field == 2'h0 |=> pin_a_oe_n) else $error("pin a driven");
endmodule
bind dual_slope_pwm_timer16 pwm_timer_props u_props (
    .mclk(mclk), .rst_n(rst_n), .timer_tick(timer_tick), .count_up_reg(count_up_reg),
    .pin_direction_a_bit(pin_direction_a_bit), .waveform_select_field(waveform_select_field),
    .output_action_a_field(output_action_a_field), .output_action_b_field(output_action_b_field),
    .count_value(count_value), .compare_a_reg(compare_a_reg), .compare_b_reg(compare_b_reg),
    .capture_top_reg(capture_top_reg), .overflow_flag(overflow_flag), .compare_a_flag(compare_a_flag),
    .capture_flag(capture_flag), .compare_output_a(compare_output_a), .compare_output_b(compare_output_b),
    .pin_a_oe_n(pin_a_oe_n));

// ==== verification/pwm_pin_load.sv ====
// external load on one compare output pin
`timescale 1ns/1ps
module pwm_pin_load (
    input  wire drive,
    input  wire oe_n,
    output wire level
);
    // pull-down takes the pin whenever the timer lets go of it
    assign level = oe_n ? 1'b0 : drive;
endmodule

// ==== verification/dual_slope_pwm_timer16_bench.sv ====
// self-checking bench for the dual-slope pwm timer
`timescale 1ns/1ps
`define CK(nm, e, g) begin comparisons = comparisons + 1; if ((g) !== (e)) begin n_errors = n_errors + 1; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module dual_slope_pwm_timer16_bench;
    reg         mclk, rst_n, tick, dir_a, wr_a, wr_b, wr_c, clr;
    reg  [3:0]  mode;
    reg  [1:0]  act_a, act_b;
    reg  [15:0] wd, top;
    wire [15:0] cnt, cmp_a, cmp_b, cap;
    wire        up, ovf, flag_a, flag_b, flag_c, out_a, out_b, oe_a_n, oe_b_n, pin_a, pin_b;
    integer     n_errors, comparisons, i, k, len;
    // all four clear strobes share one line
    dual_slope_pwm_timer16 u_dut (.mclk(mclk), .rst_n(rst_n), .timer_tick(tick), .waveform_select_field(mode),
        .output_action_a_field(act_a), .output_action_b_field(act_b), .pin_direction_a_bit(dir_a),
        .pin_direction_b_bit(1'b1), .write_data(wd), .compare_a_write(wr_a), .compare_b_write(wr_b),
        .capture_write(wr_c), .overflow_clear(clr), .compare_a_clear(clr), .compare_b_clear(clr),
        .capture_clear(clr), .count_value(cnt), .compare_a_reg(cmp_a), .compare_b_reg(cmp_b),
        .capture_top_reg(cap), .count_up_reg(up), .overflow_flag(ovf), .compare_a_flag(flag_a),
        .compare_b_flag(flag_b), .capture_flag(flag_c), .compare_output_a(out_a), .compare_output_b(out_b),
        .pin_a_oe_n(oe_a_n), .pin_b_oe_n(oe_b_n));
    pwm_pin_load u_load_a (.drive(out_a), .oe_n(oe_a_n), .level(pin_a));
    pwm_pin_load u_load_b (.drive(out_b), .oe_n(oe_b_n), .level(pin_b));
    // sel 0 compare a, 1 compare b, 2 capture
    task wr(input integer sel, input [15:0] d);
        begin
            @(negedge mclk);
            wd = d;
            wr_a = (sel == 0);
            wr_b = (sel == 1);
            wr_c = (sel == 2);
            @(negedge mclk);
            wr_a = 0;
            wr_b = 0;
            wr_c = 0;
        end
    endtask
    // bounded so a missed value cannot hang the run
    task wait_cnt(input [15:0] v);
        for (k = 0; cnt !== v && k < 3000; k = k + 1) @(negedge mclk);
    endtask
    task span(input sel, input lvl);
        for (len = 0; (sel ? pin_b : pin_a) === lvl && len < 2000; len = len + 1) @(negedge mclk);
    endtask
    // skip a partial high and the low after it, then time a whole high
    task high_run(input sel);
        begin
            span(sel, 1);
            span(sel, 0);
            span(sel, 1);
        end
    endtask
    task restart(input [3:0] m);
        begin
            rst_n = 0;
            mode = m;
            repeat (10) @(negedge mclk);
            rst_n = 1;
        end
    endtask
    task complete_run;
        begin
            if (n_errors == 0 && comparisons > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    initial begin
        mclk = 0;
        forever #10 mclk = ~mclk;
    end
    // the planned run is under ten thousand cycles
    initial begin
        repeat (40000) @(posedge mclk);
        n_errors = n_errors + 1;
        complete_run;
    end
    initial begin
        n_errors = 0;
        comparisons = 0;
        // 26 bits in all: tick and direction high, the rest idle
        {tick, dir_a, clr, wr_a, wr_b, wr_c, act_a, act_b, wd} = {2'b11, 24'h0};
        for (i = 1; i <= 3; i = i + 1) begin
            restart(i[3:0]);
            top = (16'h0100 << (i - 1)) - 16'h0001;
            wr(0, 16'hffff);
            `CK("buffered cmp a", 16'h0000, cmp_a)
            `CK("start overflow", 1'b1, ovf)
            wait_cnt(top);
            @(negedge mclk);
            `CK("count after top", top - 16'h0001, cnt)
            `CK("masked cmp a", top, cmp_a)
        end
        restart(4'h1);
        act_a = 2'h3;
        act_b = 2'h2;
        wr(0, 16'h0040);
        wr(1, 16'h0080);
        high_run(0);
        `CK("inverted a high", 382, len)
        high_run(1);
        `CK("non-inverted b high", 256, len)
        wait_cnt(16'h0080);
        clr = 1;
        @(negedge mclk);
        clr = 0;
        `CK("overflow cleared", 1'b0, ovf)
        `CK("b flag set wins", 1'b1, flag_b)
        wait_cnt(16'h0000);
        @(negedge mclk);
        `CK("overflow at bottom", 1'b1, ovf)
        dir_a = 0;
        repeat (2) @(negedge mclk);
        `CK("pin a released", 1'b1, oe_a_n)
        `CK("pin a pulled", 1'b0, pin_a)
        dir_a = 1;
        wr(0, 16'h0000);
        wr(1, 16'h00ff);
        wait_cnt(16'h0000);
        wait_cnt(16'h00ff);
        len = 0;
        repeat (520) begin
            @(negedge mclk);
            len = len + (pin_a === 1'b1 && pin_b === 1'b1);
        end
        `CK("steady high", 520, len)
        for (i = 9; i <= 11; i = i + 2) begin
            restart(4'h0);
            wr(0, 16'h0010);
            {act_a, act_b, mode} = {4'h5, i[3:0]};
            wr(0, 16'h0010);
            wr(1, 16'h0005);
            wait_cnt(16'h0010);
            @(negedge mclk);
            `CK("cmp b at top", (i == 9) ? 16'h0000 : 16'h0005, cmp_b)
            `CK("top flag a", 1'b1, flag_a)
            wait_cnt(16'h0000);
            @(negedge mclk);
            `CK("cmp b at bottom", 16'h0005, cmp_b)
            high_run(0);
            `CK("toggle high", 32, len)
            `CK("b toggle ignored", 1'b1, oe_b_n)
        end
        for (i = 8; i <= 10; i = i + 2) begin
            restart(4'h0);
            wr(2, 16'h0020);
            mode = i[3:0];
            wr(2, 16'h0030);
            `CK("capture unbuffered", 16'h0030, cap)
            wait_cnt(16'h0030);
            @(negedge mclk);
            `CK("capture top turn", 16'h002f, cnt)
            `CK("capture flag", 1'b1, flag_c)
        end
        tick = 0;
        restart(4'h1);
        repeat (10) begin
            tick = 1;
            @(negedge mclk);
            tick = 0;
            repeat (7) @(negedge mclk);
        end
        `CK("prescaled count", 16'h000a, cnt)
        complete_run;
    end
endmodule
